// [rtl/pc_seq_params.svh]
`ifndef PC_SEQ_PARAMS_SVH
`define PC_SEQ_PARAMS_SVH

`define PC_W 11
`define WORD_W 15
`define ROM_DEPTH 2048
`define BYTE_W 8
`define PAGE_W 3
`define STK_DEPTH 4
`define STK_IDX_W 2
`define STK_CNT_W 3
`define STK_FULL 3'h4
`define RESET_VEC 11'h000
`define TIMER_VEC 11'h008
`define LAST_PAGE 3'h7
`define PHASE_W 2
`define PHASE_LAST 2'h3
`define IDX_W 8
`define IDX_TBLP 8'h07
`define IDX_TABLE_WORD_UPPER_BITS 8'h08
`define IDX_TABLE_POINTER_PAGE_BITS 8'h1f
`define IDX_CFG 8'h20
`define IDX_STAT 8'h21
`define HADDR_IDX_LO 2
`define HADDR_IDX_HI 9
`define HADDR_TOP_LO 10
`define CFG_HP_BIT 0
`define TABLE_WORD_UPPER_BITS_PAD 1'h0
`define STAT_PAD_W 19

`endif

// [rtl/pc_seq_pkg.sv]
`include "pc_seq_params.svh"

package pc_seq_pkg;

    typedef enum logic [3:0] {
        OP_SEQ = 4'h0,
        OP_SKIP = 4'h1,
        OP_JUMP = 4'h2,
        OP_CALL = 4'h3,
        OP_RET = 4'h4,
        OP_INTERRUPT_RETURN_OP = 4'h5,
        OP_PCL = 4'h6,
        OP_TAB_CUR = 4'h7,
        OP_TAB_LAST = 4'h8
    } op_t;

    typedef enum logic [1:0] {
        ST_EXEC = 2'h0,
        ST_DUMMY = 2'h1,
        ST_TABLE = 2'h2
    } state_t;

    typedef struct packed {
        logic [`PHASE_W-1:0] phase;
        state_t st;
        logic [`PC_W-1:0] pc;
        logic [`STK_DEPTH-1:0][`PC_W-1:0] stk;
        logic [`STK_IDX_W-1:0] idx;
        logic [`STK_CNT_W-1:0] depth;
        logic irq_pend;
        logic irq_ack;
        logic flush;
        logic [`PC_W-1:0] tbl_addr;
        logic [`BYTE_W-1:0] tblp;
        logic [`BYTE_W-1:0] table_pointer_page_bits;
        logic [`BYTE_W-1:0] table_word_upper_bits;
        logic hp_en;
        logic [`BYTE_W-1:0] tlow;
        logic tlow_v;
        logic dsel;
        logic dwrite;
        logic [`IDX_W-1:0] didx;
        logic [31:0] hrdata;
    } state_reg_t;

endpackage

// [rtl/pc_stack_table_read_sequencer.sv]
`include "pc_seq_params.svh"

// Contract
// - Four-entry return stack, hidden from software.
// - Call or interrupt acknowledge pushes return address.
// - Return ops load PC from popped entry.
// - Reset leaves stack index at empty top.
// - Full stack: latch request, delay acknowledge.
// - Call on full stack still pushes.
// - Reset clears PC to address zero.
// - Timer overflow vectors to eight when allowed.
// - Low byte write keeps current page bits.
// - Jump and call load all eleven bits.
// - Non-sequential change adds one dummy cycle.
// - Program memory 2K by 15 bits.
// - Table read: low byte out, rest upper.
// - Upper register read-only, top bit zero.
// - Option off: page from current PC.
// - Option on: page from pointer bits.
// - Last-page read forces page bits high.
// - High pointer option disabled by default.
// - Table reads take two instruction cycles.
// - Both table pointers readable and writable.
module pc_stack_table_read_sequencer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic op_valid,
    input wire pc_seq_pkg::op_t op,
    input wire logic [`PC_W-1:0] op_addr,
    input wire logic [`BYTE_W-1:0] op_data,
    input wire logic timer_overflow,
    input wire logic timer_irq_enable,
    input wire logic rom_we,
    input wire logic [`PC_W-1:0] rom_waddr,
    input wire logic [`WORD_W-1:0] rom_wdata,
    output logic [`PC_W-1:0] fetch_addr,
    output logic [`WORD_W-1:0] instr_word,
    output logic cycle_strobe,
    output logic op_busy,
    output logic flush,
    output logic irq_ack,
    output logic [`BYTE_W-1:0] table_low_byte,
    output logic table_low_valid
);
    import pc_seq_pkg::*;

    // One instruction cycle is four clocks. A two-bit phase counter runs
    // freely from reset, and the last phase is the only clock in which
    // the program counter, the stack and the table logic may change.
    // Everything else in the block only watches that strobe, so a slower
    // core would need nothing but a longer divider.
    //
    // The decoder offers one operation at a time and keeps it up until
    // the strobe. An operation offered while a dummy or table cycle is
    // still running is not taken and has to be offered again; the busy
    // output tells the decoder when that is the case.
    //
    // The return stack is an array of four program counter values plus a
    // two-bit index and a three-bit depth count. The index alone cannot
    // tell an empty stack from a full one, which is why the depth count
    // exists; it never leaves the block.
    //
    // Interrupts are taken only in a clock in which the decoder offers
    // nothing, so an operation always wins over a pending request.

    state_reg_t r;
    state_reg_t n;
    logic cyc;
    logic full;
    logic addr_hit;
    logic [`PC_W-1:0] rd_addr;
    logic [`WORD_W-1:0] rom_q;
    logic [`IDX_W-1:0] aidx;
    logic [`STK_IDX_W-1:0] top;

    // The program store is a plain array outside the state record, so
    // that it maps onto a memory macro rather than onto flip-flops.
    logic [`WORD_W-1:0] rom [0:`ROM_DEPTH-1];

    // While a table read is in progress the single read port serves the
    // table address; fetch is held off by op_busy during that time.
    assign rd_addr = (r.st == ST_TABLE) ? r.tbl_addr : r.pc;

    // The load port and the fetch port share one clock. A word written in
    // the same clock as it is read returns the old content, which matters
    // only to a test that loads and fetches at once. The store has no
    // reset, so its content is unknown until it has been loaded.
    // A second read port would let fetch run during table reads, at the
    // cost of a larger store; the core waits instead.
    always_ff @(posedge hclk) begin
        if (rom_we) begin
            rom[rom_waddr] <= rom_wdata;
        end
        rom_q <= rom[rd_addr];
    end

    // The phase strobe and the full flag are plain decodes of the record
    // and carry no state of their own; they settle within the clock.
    // The depth count saturates at four, so a call on a full stack is the
    // only way the index can lap the oldest entry. Reads of an empty stack
    // still move the index; software cannot see either way.
    // The entry below the index is the top of the stack. A return reads
    // it in the same clock as it moves the index down, so the popped value
    // never waits a clock in a register of its own.
    // The bus decode keeps only the word index, and a byte address beyond
    // the small register window answers as a hole rather than an alias.
    assign cyc = (r.phase == `PHASE_LAST);
    assign full = (r.depth == `STK_FULL);
    assign top = r.idx - `STK_IDX_W'(1);
    assign aidx = haddr[`HADDR_IDX_HI:`HADDR_IDX_LO];
    assign addr_hit = (haddr[31:`HADDR_TOP_LO] == '0);

    always_comb begin
        n = r;
        n.irq_ack = 1'b0;
        n.flush = 1'b0;
        n.tlow_v = 1'b0;
        n.phase = r.phase + `PHASE_W'(1);
        // The phase counter is the only field that moves in every clock.
        // Pulses default low and fall back after a single clock. The rest
        // of the record holds its value unless a branch below changes it.
        // The order of the four sections matters: the instruction step
        // comes first, the interrupt request latch after it, so that a new
        // overflow in the acknowledge clock is not lost, and the bus write
        // third, ahead of the address phase, so that a read in the next clock returns the written word.

        if (cyc) begin
            case (r.st)
                ST_EXEC: begin
                    if (op_valid) begin
                        case (op)
                            // A plain instruction just steps on.
                            OP_SEQ: begin
                                n.pc = r.pc + `PC_W'(1);
                            end
                            OP_SKIP: begin
                                // The fetched word is discarded.
                                n.pc = r.pc + `PC_W'(1);
                                n.st = ST_DUMMY;
                                n.flush = 1'b1;
                            end
                            // A jump takes the full address from the
                            // instruction and costs one dummy cycle.
                            OP_JUMP: begin
                                n.pc = op_addr;
                                n.st = ST_DUMMY;
                                n.flush = 1'b1;
                            end
                            OP_CALL: begin
                                // A full stack does not block the call;
                                // the index wraps onto the oldest slot.
                                n.stk[r.idx] = r.pc;
                                n.idx = r.idx + `STK_IDX_W'(1);
                                if (!full) begin
                                    n.depth = r.depth + `STK_CNT_W'(1);
                                end
                                n.pc = op_addr;
                                n.st = ST_DUMMY;
                                n.flush = 1'b1;
                            end
                            // The interrupt return is the same as the
                            // plain one here; re-enabling interrupts is
                            // left to the interrupt controller.
                            OP_RET, OP_INTERRUPT_RETURN_OP: begin
                                n.pc = r.stk[top];
                                n.idx = top;
                                if (r.depth != '0) begin
                                    n.depth = r.depth - `STK_CNT_W'(1);
                                end
                                n.st = ST_DUMMY;
                                n.flush = 1'b1;
                            end
                            // Only the low byte is replaced, so the jump
                            // stays inside the current 256-word page.
                            OP_PCL: begin
                                n.pc = {r.pc[`PC_W-1:`BYTE_W],
                                        op_data};
                                n.st = ST_DUMMY;
                                n.flush = 1'b1;
                            end
                            // Both table ops move on to the next word at
                            // once and spend one whole extra cycle on the
                            // read. The program counter is not touched by
                            // the read itself.
                            OP_TAB_CUR: begin
                                if (r.hp_en) begin
                                    n.tbl_addr = {r.table_pointer_page_bits[`PAGE_W-1:0],
                                                  r.tblp};
                                end else begin
                                    n.tbl_addr = {r.pc[`PC_W-1:`BYTE_W],
                                                  r.tblp};
                                end
                                n.pc = r.pc + `PC_W'(1);
                                n.st = ST_TABLE;
                            end
                            OP_TAB_LAST: begin
                                n.tbl_addr = {`LAST_PAGE,
                                              r.tblp};
                                n.pc = r.pc + `PC_W'(1);
                                n.st = ST_TABLE;
                            end
                            default: begin
                                n.pc = r.pc + `PC_W'(1);
                            end
                        endcase
                    end else if (r.irq_pend && timer_irq_enable &&
                                 !full) begin
                        // A full stack keeps the request pending until
                        // a return frees an entry.
                        n.stk[r.idx] = r.pc;
                        n.idx = r.idx + `STK_IDX_W'(1);
                        n.depth = r.depth + `STK_CNT_W'(1);
                        n.pc = `TIMER_VEC;
                        n.irq_pend = 1'b0;
                        n.irq_ack = 1'b1;
                        n.st = ST_DUMMY;
                        n.flush = 1'b1;
                    end
                end
                // The dummy cycle replaces the discarded prefetch while the
                // word at the new address is being fetched. Nothing else
                // happens in it; even a pending interrupt has to wait.
                ST_DUMMY: begin
                    n.st = ST_EXEC;
                end
                // The table address went to the store at the start of the
                // cycle, so the word has stood on rom_q for several clocks
                // by now. The upper register changes only here, which is
                // why an interrupt routine that reads tables must save it.
                ST_TABLE: begin
                    n.table_word_upper_bits = {`TABLE_WORD_UPPER_BITS_PAD,
                              rom_q[`WORD_W-1:`BYTE_W]};
                    n.tlow = rom_q[`BYTE_W-1:0];
                    n.tlow_v = 1'b1;
                    n.st = ST_EXEC;
                end
                default: begin
                    n.st = ST_EXEC;
                end
            endcase
        end

        // The request is latched only while the enable is high; an
        // overflow seen with the enable low is dropped for good.
        // A new overflow in the acknowledge cycle stays pending.
        if (timer_overflow && timer_irq_enable) begin
            n.irq_pend = 1'b1;
        end

        // Writes are applied one clock late, in the data phase, because
        // that is when the master puts the word on hwdata.
        // Data phase of a bus write. The upper table register, the stack
        // and its index have no write path at all.
        if (r.dsel && r.dwrite) begin
            case (r.didx)
                `IDX_TBLP: begin
                    n.tblp = hwdata[`BYTE_W-1:0];
                end
                `IDX_TABLE_POINTER_PAGE_BITS: begin
                    n.table_pointer_page_bits = hwdata[`BYTE_W-1:0];
                end
                `IDX_CFG: begin
                    n.hp_en = hwdata[`CFG_HP_BIT];
                end
                default: begin
                    n.hp_en = n.hp_en;
                end
            endcase
        end

        // The status word gives the program counter, the busy flag and
        // the pending request for debug. The size of the transfer is not
        // decoded; every register is a whole word with its data in the
        // low bits and zeros above.
        // Address phase. Read data is taken from the next state so that a
        // read right behind a write to the same word sees the new value.
        n.dsel = 1'b0;
        n.dwrite = 1'b0;
        if (hsel && htrans[1] && hready) begin
            n.dsel = addr_hit;
            n.dwrite = hwrite;
            n.didx = aidx;
            n.hrdata = '0;
            if (!hwrite && addr_hit) begin
                case (aidx)
                    `IDX_TBLP: begin
                        n.hrdata = {24'h000000, n.tblp};
                    end
                    `IDX_TABLE_WORD_UPPER_BITS: begin
                        n.hrdata = {24'h000000, n.table_word_upper_bits};
                    end
                    `IDX_TABLE_POINTER_PAGE_BITS: begin
                        n.hrdata = {24'h000000, n.table_pointer_page_bits};
                    end
                    `IDX_CFG: begin
                        n.hrdata = {31'h00000000, n.hp_en};
                    end
                    `IDX_STAT: begin
                        // The stack index is deliberately left out.
                        n.hrdata = {{`STAT_PAD_W{1'b0}}, r.irq_pend,
                                    (r.st != ST_EXEC), r.pc};
                    end
                    default: begin
                        n.hrdata = '0;
                    end
                endcase
            end
        end
    end

    // Every field is reset to a constant. The stack entries are cleared as
    // well, since a return on an empty stack still loads one of them; this keeps
    // a return without a call from handing out an unknown address.
    // The phase counter starts at zero, so the first strobe after reset
    // comes three clocks after the release.
    // The program store is not part of the record and keeps its content
    // through a reset, like a real program memory would.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.phase <= '0;
            r.st <= ST_EXEC;
            r.pc <= `RESET_VEC;
            r.stk <= '0;
            r.idx <= '0;
            r.depth <= '0;
            r.irq_pend <= 1'b0;
            r.irq_ack <= 1'b0;
            r.flush <= 1'b0;
            r.tbl_addr <= '0;
            r.tblp <= '0;
            r.table_pointer_page_bits <= '0;
            r.table_word_upper_bits <= '0;
            r.hp_en <= 1'b0;
            r.tlow <= '0;
            r.tlow_v <= 1'b0;
            r.dsel <= 1'b0;
            r.dwrite <= 1'b0;
            r.didx <= '0;
            r.hrdata <= '0;
        end else begin
            r <= n;
        end
    end

    // The bus never stalls: every register answers in the clock after
    // its address phase, and the response is always good. Outputs to the
    // core are taken from the record or from rom_q, so none of them glitch.
    // The busy flag and the cycle strobe are the only ones derived from the
    // state, and both come from registers as well.
    // Note that table_low_valid and irq_ack are single-clock pulses: the
    // core must take them in the clock in which they stand, since nothing
    // holds them for a late reader.
    assign hrdata = r.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign fetch_addr = r.pc;
    assign instr_word = rom_q;
    assign cycle_strobe = cyc;
    assign op_busy = (r.st != ST_EXEC);
    assign flush = r.flush;
    assign irq_ack = r.irq_ack;
    assign table_low_byte = r.tlow;
    assign table_low_valid = r.tlow_v;

endmodule

// [testbench/pc_seq_decoder_model.sv]
`include "pc_seq_params.svh"

module pc_seq_decoder_model (
    input wire logic go,
    input wire pc_seq_pkg::op_t cmd,
    input wire logic [`PC_W-1:0] cmd_addr,
    input wire logic [`BYTE_W-1:0] cmd_data,
    input wire logic cycle_strobe,
    input wire logic op_busy,
    output logic op_valid,
    output pc_seq_pkg::op_t op,
    output logic [`PC_W-1:0] op_addr,
    output logic [`BYTE_W-1:0] op_data,
    output logic taken
);
    timeunit 1ns;
    timeprecision 1ps;
    import pc_seq_pkg::*;
    // Idle address and data fields carry inverted values and the idle op is
    // OP_SEQ, so a design that ignores the valid level sees garbage rather than a lucky match.
    always_comb begin
        op_valid = go;
        op = go ? cmd : OP_SEQ;
        op_addr = go ? cmd_addr : ~cmd_addr;
        op_data = go ? cmd_data : ~cmd_data;
        taken = go && cycle_strobe && !op_busy;
    end
endmodule

// [testbench/pc_seq_props.sv]
`include "pc_seq_params.svh"

module pc_seq_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic op_valid,
    input wire pc_seq_pkg::op_t op,
    input wire logic [`PC_W-1:0] op_addr,
    input wire logic [`BYTE_W-1:0] op_data,
    input wire logic timer_irq_enable,
    input wire logic [`PC_W-1:0] fetch_addr,
    input wire logic cycle_strobe,
    input wire logic op_busy,
    input wire logic flush,
    input wire logic irq_ack,
    input wire logic table_low_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import pc_seq_pkg::*;
    logic take;
    logic [2:0] page;
    assign take = cycle_strobe && !op_busy && op_valid;
    assign page = fetch_addr[10:8];
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_reset_pc;
        !$past(hresetn) |-> fetch_addr == `RESET_VEC;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("pc");
    property p_jump;
        take && op inside {OP_JUMP, OP_CALL} |=> fetch_addr == $past(op_addr);
    endproperty
    a_jump: assert property (p_jump) else $error("jump");
    property p_pcl;
        take && op == OP_PCL |=> {page, 8'h00} == {$past(page), 8'h00}
            && fetch_addr[7:0] == $past(op_data);
    endproperty
    a_pcl: assert property (p_pcl) else $error("pcl");
    property p_dummy;
        take && op inside {OP_SKIP, OP_JUMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN_OP, OP_PCL}
            |=> flush ##0 op_busy [*4] ##1 !op_busy;
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy");
    property p_flush_cause;
        flush |-> $past(take) || irq_ack;
    endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("fl");
    property p_table;
        take && op inside {OP_TAB_CUR, OP_TAB_LAST}
            |=> op_busy [*4] ##1 (table_low_valid && !op_busy);
    endproperty
    a_table: assert property (p_table) else $error("table");
    property p_ack_cause;
        irq_ack |-> $past(cycle_strobe && !op_busy && !op_valid)
            && $past(timer_irq_enable);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack");
    property p_vec;
        irq_ack |-> fetch_addr == `TIMER_VEC && flush;
    endproperty
    a_vec: assert property (p_vec) else $error("vector");
endmodule

bind pc_stack_table_read_sequencer pc_seq_props i_pc_seq_props (.*);

// [testbench/pc_stack_table_read_sequencer_test.sv]
`include "pc_seq_params.svh"

module pc_stack_table_read_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pc_seq_pkg::*;
    logic hclk, hready, hreadyout, hresp, taken, op_valid;
    logic hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, go = 1'h0;
    logic rom_we = 1'h0, timer_overflow = 1'h0, timer_irq_enable = 1'h1;
    logic [2:0] hsize = 3'h2;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    op_t cmd = OP_SEQ, op;
    logic [10:0] cmd_addr = '0, rom_waddr = '0, op_addr, fetch_addr, pre, q;
    logic [10:0] p [4], e [4];
    logic [7:0] cmd_data = '0, op_data, table_low_byte;
    logic [14:0] rom_wdata = '0, instr_word;
    logic cycle_strobe, op_busy, flush, irq_ack, table_low_valid;
    int mismatches, checks, acks, n;
    logic [10:0] ta [3] = '{11'h705, 11'h205, 11'h605};
    logic [14:0] tw [3] = '{15'h3a5c, 15'h1234, 15'h6e01};
    logic [31:0] rows [3][3] = '{'{32'h1c, 32'ha5, 32'ha5},
        '{32'h7c, 32'h05, 32'h05}, '{32'h40, 32'hff, 32'h00}};
    assign hready = hreadyout;
    pc_stack_table_read_sequencer i_pc_stack_table_read_sequencer (.*);
    pc_seq_decoder_model i_pc_seq_decoder_model (.*);
    initial begin
        hclk = 1'h0;
        forever #25 hclk = ~hclk;
    end
    always @(negedge hclk) acks += (irq_ack === 1'h1);
    task chk(input string s, input logic [31:0] seen, input logic [31:0] ex);
        checks++;
        if (seen !== ex) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", s, ex, seen);
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
    endtask
    // Returns at the falling edge after the op was taken, when the new
    // program counter has settled; pre holds the value before it.
    task do_op(input op_t o, input logic [10:0] a, input logic [7:0] d);
        @(posedge hclk);
        go <= 1'h1;
        cmd <= o;
        cmd_addr <= a;
        cmd_data <= d;
        do @(negedge hclk); while (taken !== 1'h1);
        pre = fetch_addr;
        @(posedge hclk);
        go <= 1'h0;
        @(negedge hclk);
    endtask
    task tab(input op_t o, input int i);
        do_op(o, 11'h0, 8'h0);
        repeat (8) begin
            if (table_low_valid === 1'h1) break;
            @(negedge hclk);
        end
        chk("low", 32'(table_low_byte), 32'(tw[i][7:0]));
        ahb(1'h0, 32'h20, 32'h0);
        chk("upper", rd, 32'(tw[i][14:8]));
    endtask
    // q keeps the program counter of the cycle before the acknowledge.
    task wack;
        repeat (60) begin
            @(negedge hclk);
            if (irq_ack === 1'h1) break;
            q = fetch_addr;
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        @(negedge hclk);
        chk("pc", 32'(fetch_addr), 32'h0);
        ahb(1'h0, 32'h80, 32'h0);
        chk("option", rd, 32'h0);
        foreach (rows[i]) begin
            ahb(1'h1, rows[i][0], rows[i][1]);
            ahb(1'h0, rows[i][0], 32'h0);
            chk("reg", rd, rows[i][2]);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            rom_we <= 1'h1;
            rom_waddr <= ta[i];
            rom_wdata <= tw[i];
        end
        @(posedge hclk);
        rom_we <= 1'h0;
        ahb(1'h1, 32'h1c, 32'h05);
        tab(OP_TAB_LAST, 0);
        do_op(OP_JUMP, 11'h2f0, 8'h0);
        chk("jump", 32'(fetch_addr), 32'h2f0);
        tab(OP_TAB_CUR, 1);
        ahb(1'h1, 32'h7c, 32'h06);
        ahb(1'h1, 32'h80, 32'h1);
        tab(OP_TAB_CUR, 2);
        ahb(1'h1, 32'h20, 32'hff);
        ahb(1'h0, 32'h20, 32'h0);
        chk("ro", rd, 32'(tw[2][14:8]));
        do_op(OP_PCL, 11'h0, 8'h12);
        chk("pcl", 32'(fetch_addr), 32'({pre[10:8], 8'h12}));
        for (int i = 0; i < 4; i++) begin
            do_op(OP_CALL, 11'((i + 1) << 8), 8'h0);
            p[i] = pre;
        end
        n = acks;
        @(posedge hclk);
        timer_overflow <= 1'h1;
        @(posedge hclk);
        timer_overflow <= 1'h0;
        repeat (16) @(posedge hclk);
        chk("held", 32'(acks - n), 32'h0);
        do_op(OP_RET, 11'h0, 8'h0);
        chk("ret", 32'(fetch_addr), 32'(p[3]));
        wack;
        chk("ack", 32'(irq_ack), 32'h1);
        chk("vec", 32'(fetch_addr), 32'h8);
        do_op(OP_CALL, 11'h500, 8'h0);
        e = '{pre, q, p[2], p[1]};
        for (int i = 0; i < 4; i++) begin
            do_op(i[0] ? OP_INTERRUPT_RETURN_OP : OP_RET, 11'h0, 8'h0);
            chk("unwind", 32'(fetch_addr), 32'(e[i]));
        end
        // Fill the stack, reset in mid-run, and expect an interrupt to be
        // taken at once, which only an emptied stack allows.
        for (int i = 0; i < 4; i++) begin
            do_op(OP_CALL, 11'h100, 8'h0);
        end
        @(posedge hclk);
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(negedge hclk);
        chk("pc2", 32'(fetch_addr), 32'h0);
        ahb(1'h0, 32'h84, 32'h0);
        chk("status", rd, 32'h0);
        chk("resp", 32'(hresp), 32'h0);
        @(posedge hclk);
        timer_overflow <= 1'h1;
        @(posedge hclk);
        timer_overflow <= 1'h0;
        wack;
        chk("empty", 32'(irq_ack), 32'h1);
        chk("vec2", 32'(fetch_addr), 32'h8);
        do_op(OP_SKIP, 11'h0, 8'h0);
        chk("skip", 32'(fetch_addr), 32'(pre + 11'h1));
        do_op(OP_JUMP, 11'h705, 8'h0);
        @(negedge hclk);
        chk("word", 32'(instr_word), 32'(tw[0]));
        close_out;
    end
endmodule
